// ==== fcl_pkg.sv ====
// constants for the flash command launch block
// Operation
// - reserved register at index 0x13 reads zero and ignores writes
// - special-mode input 0 gives normal mode, 1 special mode
// - version word holds version number in bits 3:0, 0000/1111 mean none
// - writing the divider register sets the divider-loaded flag
// - program or erase without loaded divider sets access error, not run
// - while completion flag is zero, launches and command array writes ignored
// - command index field selects which array word an access reaches
// - writing 1 to completion flag clears it and launches the command
// - flag stays clear until done, then sets with results readable
// - erase-verify commands 0x01, 0x02 allowed in every mode
// - erase-all 0x08 and unsecure 0x0B allowed only in special mode
// - verify-backdoor-key 0x0C allowed only in normal mode
// - set-field-margin 0x0E allowed only in unsecured special mode
// - other commands refused only in secured special mode
// - erase verify of all, one block or a section reports erased state
// - read-once 0x04 and program-once 0x07 of one-time field
// - 0x06 programs a phrase, 0x0A erases a sector
// - erase-all needs all protect bits open; block erase needs program ones
// - security released by unsecure erase or matching backdoor key
// - command code is the high byte of array word zero
// - invalid command code sets access error and is not processed
package fcl_pkg;
  // ************************************************
  // bus and register map (index, byte address = 4 x index)
  // ************************************************
  localparam int AW = 10;
  localparam logic [7:0] IX_CLKDIV = 8'h00;
  localparam logic [7:0] IX_COMMAND_INDEX_FIELD = 8'h02;
  localparam logic [7:0] IX_STAT = 8'h06;
  localparam logic [7:0] IX_PROGRAM_PROTECT_REG = 8'h08;
  localparam logic [7:0] IX_DATA_PROTECT_REG = 8'h09;
  localparam logic [7:0] IX_CCOB = 8'h0A;
  localparam logic [7:0] IX_RSV7 = 8'h13;
  localparam logic [7:0] IX_VER = 8'h14;
  localparam logic [7:0] IX_SEC = 8'h15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int CD_LD = 7;
  localparam int DIVIDER_FIELD_W = 6;
  localparam int ST_COMMAND_COMPLETE_FLAG = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int ST_MG0 = 0;
  localparam int FP_OPEN = 7;
  localparam int FP_HDIS = 5;
  localparam int FP_LDIS = 2;
  localparam int DF_OPEN = 7;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam int CCOB_WORDS = 6;
  localparam int VER_W = 4;
  // ************************************************
  // command codes
  // ************************************************
  localparam logic [7:0] C_EVALL = 8'h01;
  localparam logic [7:0] C_EVBLK = 8'h02;
  localparam logic [7:0] C_EVPSEC = 8'h03;
  localparam logic [7:0] C_RDONCE = 8'h04;
  localparam logic [7:0] C_PGMP = 8'h06;
  localparam logic [7:0] C_PGMONCE = 8'h07;
  localparam logic [7:0] C_ERALL = 8'h08;
  localparam logic [7:0] C_ERBLK = 8'h09;
  localparam logic [7:0] C_ERPSEC = 8'h0A;
  localparam logic [7:0] C_UNSEC = 8'h0B;
  localparam logic [7:0] C_VFYKEY = 8'h0C;
  localparam logic [7:0] C_USRMRG = 8'h0D;
  localparam logic [7:0] C_FLDMRG = 8'h0E;
  localparam logic [7:0] C_EVDSEC = 8'h10;
  localparam logic [7:0] C_PGMD = 8'h11;
  localparam logic [7:0] C_ERDSEC = 8'h12;
  // ************************************************
  // timing: time base target and bus clock rate
  // ************************************************
  localparam int TB_KHZ = 1000;
  localparam int MCLK_KHZ = 20000;
  localparam logic [5:0] DIVIDER_FIELD_HINT = 6'(MCLK_KHZ / TB_KHZ - 1);
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} fcl_state_t;
endpackage

// ==== fcl_tb.sv ====
// self-checking bench for the flash command launch front end
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fcl_pkg::*;
  // ************************************************
  // signals and bookkeeping
  // ************************************************
  localparam int RUN = 4 * (int'(DIVIDER_FIELD_HINT) + 1); // exec ticks times divider plus one
  logic mclk = 1'b0, reset_n = 1'b0, special_mode_input = 1'b0, chip_secured = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, security_released;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [65:0] rq[$]; // expected read: resp, mask, data
  logic [1:0] bq[$]; // expected write response
  int err_total = 0, comparisons = 0, seed = 4;
  logic [31:0] rnd;
  fcl_top #(.EXEC_TICKS(4), .VERSION(4'h1)) u_dut (.mclk(mclk), .reset_n(reset_n),
    .special_mode_input(special_mode_input), .chip_secured(chip_secured), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .security_released(security_released));
  // 20 MHz bus clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ************************************************
  // comparison, verdict and bus tasks
  // ************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic [3:0] st, input logic [1:0] rs);
    bit pend;
    pend = 1;
    bq.push_back(rs);
    @(posedge mclk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pend) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        pend = 0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] m, input logic [31:0] e, input logic [1:0] rs);
    bit pend;
    pend = 1;
    rq.push_back({rs, m, e & m});
    @(posedge mclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pend) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        pend = 0;
      end
    end
  endtask
  // monitor: every answer is matched against the oldest note
  always @(posedge mclk) begin
    logic [65:0] n;
    if (s_axi_rvalid && s_axi_rready) begin
      n = rq.pop_front();
      check(s_axi_rdata & n[63:32], n[31:0]);
      check(32'(s_axi_rresp), 32'(n[65:64]));
    end
    if (s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), 32'(bq.pop_front()));
  end
  // ************************************************
  // scenarios
  // ************************************************
  function automatic bit allowed(input logic [7:0] c, input bit sp, input bit sec);
    case (c)
      C_EVALL, C_EVBLK: allowed = 1;
      C_ERALL, C_UNSEC: allowed = sp;
      C_VFYKEY: allowed = !sp;
      C_FLDMRG: allowed = sp && !sec;
      C_EVPSEC, C_RDONCE, C_PGMP, C_PGMONCE, C_ERBLK, C_ERPSEC, C_USRMRG, C_EVDSEC, C_PGMD, C_ERDSEC:
        allowed = !(sp && sec);
      default: allowed = 0;
    endcase
  endfunction
  // load word zero, launch, then look at the flags just after the launch and again after the run
  task automatic launch(input logic [7:0] c, input logic [7:0] fl);
    wr(IX_COMMAND_INDEX_FIELD, 32'h0, 4'h1, RESP_OKAY);
    wr(IX_CCOB, {16'h0, c, 8'h00}, 4'h3, RESP_OKAY);
    wr(IX_STAT, 32'h80, 4'h1, RESP_OKAY);
    rd(IX_STAT, 32'hB0, {24'h0, fl}, RESP_OKAY);
    if (fl == 8'h00) begin
      rnd = $random(seed);
      wr(IX_CCOB, rnd, 4'h3, RESP_OKAY);
      repeat (RUN + 8) @(posedge mclk);
      rd(IX_STAT, 32'h80, 32'h80, RESP_OKAY);
      rd(IX_CCOB, 32'hFF00, {16'h0, c, 8'h00}, RESP_OKAY);
    end
    wr(IX_STAT, 32'h30, 4'h1, RESP_OKAY);
  endtask
  // reset into one mode, load divider and open all protection
  task automatic setup(input bit sp, input bit sec);
    @(posedge mclk);
    reset_n <= 1'b0;
    special_mode_input <= sp;
    chip_secured <= sec;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(IX_CLKDIV, 32'hFF, 32'h00, RESP_OKAY);
    rd(IX_STAT, 32'hB0, 32'h80, RESP_OKAY);
    wr(IX_CLKDIV, {26'h0, DIVIDER_FIELD_HINT}, 4'h1, RESP_OKAY);
    rd(IX_CLKDIV, 32'hFF, {24'h0, 2'b10, DIVIDER_FIELD_HINT}, RESP_OKAY);
    wr(IX_PROGRAM_PROTECT_REG, 32'hA4, 4'h1, RESP_OKAY);
    wr(IX_DATA_PROTECT_REG, 32'h80, 4'h1, RESP_OKAY);
  endtask
  logic [7:0] codes[19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h0E,
    8'h10, 8'h11, 8'h12, 8'h0C, 8'h05, 8'h0F, 8'h13, 8'h08, 8'h0B};
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    launch(C_PGMP, 8'hA0);
    rd(IX_CLKDIV, 32'h80, 32'h00, RESP_OKAY);
    wr(IX_RSV7, 32'hFF, 4'hF, RESP_OKAY);
    rd(IX_RSV7, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(IX_VER, 32'hF, 32'h1, RESP_OKAY);
    rd(8'hFF, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(8'hFF, 32'h1, 4'hF, RESP_SLVERR);
    $display("test reset_map done");
    setup(0, 0);
    rnd = $random(seed);
    wr(IX_COMMAND_INDEX_FIELD, 32'h3, 4'h1, RESP_OKAY);
    wr(IX_CCOB, rnd, 4'h3, RESP_OKAY);
    wr(IX_COMMAND_INDEX_FIELD, 32'h6, 4'h1, RESP_OKAY);
    wr(IX_CCOB, ~rnd, 4'h3, RESP_OKAY);
    rd(IX_CCOB, 32'hFFFF, 32'h0, RESP_OKAY);
    wr(IX_COMMAND_INDEX_FIELD, 32'h3, 4'h1, RESP_OKAY);
    rd(IX_CCOB, 32'hFFFF, rnd, RESP_OKAY);
    wr(IX_PROGRAM_PROTECT_REG, 32'h24, 4'h1, RESP_OKAY);
    launch(C_ERBLK, 8'h90);
    $display("test index_protect done");
    for (int m = 0; m < 4; m++) begin
      setup(m[1], m[0]);
      foreach (codes[i]) launch(codes[i], allowed(codes[i], m[1], m[0]) ? 8'h00 : 8'hA0);
      $display("test mode %0d done", m);
    end
    // still in special mode, now released: protection, erased state and release level
    wr(IX_PROGRAM_PROTECT_REG, 32'h24, 4'h1, RESP_OKAY);
    launch(C_ERALL, 8'h90);
    launch(C_PGMP, 8'h00);
    launch(C_EVALL, 8'h00);
    rd(IX_STAT, 32'h01, 32'h01, RESP_OKAY);
    rd(IX_SEC, 32'h7, 32'h5, RESP_OKAY);
    check(32'(security_released), 32'h1);
    $display("test release_verify done");
    conclude();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire

// ==== fcl_top.sv ====
// flash command launch front end with AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fcl_top #(
  parameter int EXEC_TICKS = 4,
  parameter logic [3:0] VERSION = 4'h1, // arbitrary value
  parameter logic [63:0] BKDOOR_KEY = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic special_mode_input,
  input wire logic chip_secured,
  input wire logic [fcl_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fcl_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic security_released
);
  import fcl_pkg::*;

  // ************************************************
  // state
  // ************************************************
  logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic div_ld_r, command_complete_flag_r, access_error_flag_r, protection_violation_flag_r, mg0_r;
  logic [DIVIDER_FIELD_W-1:0] divider_field_r, pre_r;
  logic [2:0] command_index_field_r;
  logic [7:0] program_protect_reg_r, data_protect_reg_r, cmd_r;
  logic [15:0] ccob_r [CCOB_WORDS];
  logic [15:0] once_word_r;
  logic once_done_r, erased_r, sec_rel_r;
  logic [7:0] ticks_r;
  fcl_state_t st_r;

  // ************************************************
  // write decode
  // ************************************************
  wire do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  wire [7:0] wr_ix = awaddr_r[9:2];
  wire wr_mapped = wr_ix inside {IX_CLKDIV, IX_COMMAND_INDEX_FIELD, IX_STAT, IX_PROGRAM_PROTECT_REG, IX_DATA_PROTECT_REG, IX_CCOB,
                                 IX_RSV7, IX_VER, IX_SEC};
  wire wr_lo = do_wr && wstrb_r[0];
  // normal mode locks the divider after its first load; special mode may reload
  wire wr_div = wr_lo && wr_ix == IX_CLKDIV && command_complete_flag_r && (special_mode_input || !div_ld_r);
  wire wr_ix_reg = wr_lo && wr_ix == IX_COMMAND_INDEX_FIELD && command_complete_flag_r;
  wire wr_stat = wr_lo && wr_ix == IX_STAT;
  wire wr_program_protect_reg = wr_lo && wr_ix == IX_PROGRAM_PROTECT_REG && command_complete_flag_r;
  wire wr_data_protect_reg = wr_lo && wr_ix == IX_DATA_PROTECT_REG && command_complete_flag_r;
  wire wr_ccob = do_wr && wr_ix == IX_CCOB && command_complete_flag_r;

  // ************************************************
  // launch checks
  // ************************************************
  wire sec_eff = chip_secured && !sec_rel_r;
  wire sp = special_mode_input;
  wire [7:0] lcmd = ccob_r[0][15:8];
  // launch needs the flag high and both error flags already clear
  wire launch = wr_stat && wdata_r[ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_r && !access_error_flag_r && !protection_violation_flag_r;
  logic cmd_ok;
  // command availability per mode and security
  always_comb begin
    unique case (lcmd)
      C_EVALL, C_EVBLK: cmd_ok = 1'b1;
      C_ERALL, C_UNSEC: cmd_ok = sp;
      C_VFYKEY: cmd_ok = !sp;
      C_FLDMRG: cmd_ok = sp && !sec_eff;
      C_EVPSEC, C_RDONCE, C_PGMP, C_PGMONCE, C_ERBLK, C_ERPSEC, C_USRMRG, C_EVDSEC, C_PGMD,
      C_ERDSEC: cmd_ok = !(sp && sec_eff);
      default: cmd_ok = 1'b0;
    endcase
  end
  wire is_pe = lcmd inside {C_PGMP, C_PGMONCE, C_ERALL, C_ERBLK, C_ERPSEC, C_UNSEC, C_PGMD, C_ERDSEC};
  wire pf_open = program_protect_reg_r[FP_OPEN] && program_protect_reg_r[FP_HDIS] && program_protect_reg_r[FP_LDIS];
  // mass erases need the protection opened beforehand
  wire prot_ok = (lcmd == C_ERALL) ? (pf_open && data_protect_reg_r[DF_OPEN]) :
                 (lcmd == C_ERBLK) ? pf_open : 1'b1;
  wire acc_fail = !cmd_ok || (is_pe && !div_ld_r) || (lcmd == C_PGMONCE && once_done_r);
  wire start = launch && !acc_fail && prot_ok;
  wire tick = pre_r == divider_field_r;
  wire run_done = st_r == ST_RUN && tick && ticks_r == 8'(EXEC_TICKS - 1);
  wire [63:0] key_in = {ccob_r[1], ccob_r[2], ccob_r[3], ccob_r[4]};

  // ************************************************
  // read decode
  // ************************************************
  wire [7:0] rd_ix = s_axi_araddr[9:2];
  wire rd_go = s_axi_arvalid && arready_r;
  wire [15:0] ccob_rd = (command_index_field_r < 3'(CCOB_WORDS)) ? ccob_r[command_index_field_r] : 16'h0000;
  wire [7:0] stat_rd = {command_complete_flag_r, 1'b0, access_error_flag_r, protection_violation_flag_r, 3'h0, mg0_r};
  wire [31:0] rd_data =
    (rd_ix == IX_CLKDIV) ? {24'h0, div_ld_r, 1'b0, divider_field_r} :
    (rd_ix == IX_COMMAND_INDEX_FIELD) ? {29'h0, command_index_field_r} :
    (rd_ix == IX_STAT) ? {24'h0, stat_rd} :
    (rd_ix == IX_PROGRAM_PROTECT_REG) ? {24'h0, program_protect_reg_r} :
    (rd_ix == IX_DATA_PROTECT_REG) ? {24'h0, data_protect_reg_r} :
    (rd_ix == IX_CCOB) ? {16'h0, ccob_rd} :
    (rd_ix == IX_VER) ? {28'h0, VERSION} :
    (rd_ix == IX_SEC) ? {29'h0, sec_rel_r, sec_eff, sp} :
    32'h0; // reserved index reads zero
  wire rd_mapped = rd_ix inside {IX_CLKDIV, IX_COMMAND_INDEX_FIELD, IX_STAT, IX_PROGRAM_PROTECT_REG, IX_DATA_PROTECT_REG, IX_CCOB,
                                 IX_RSV7, IX_VER, IX_SEC};

  // ************************************************
  // AXI4-Lite write channel
  // ************************************************
  // address and data are caught independently, so either may come first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_r <= 1'b0;
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid && wready_r) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ************************************************
  // AXI4-Lite read channel
  // ************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (rd_go) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************
  // configuration registers
  // ************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_ld_r <= 1'b0;
      divider_field_r <= '0;
      command_index_field_r <= 3'h0;
      program_protect_reg_r <= PROT_RST;
      data_protect_reg_r <= PROT_RST;
    end else begin
      if (wr_div) begin
        div_ld_r <= 1'b1;
        divider_field_r <= wdata_r[DIVIDER_FIELD_W-1:0];
      end
      if (wr_ix_reg) command_index_field_r <= wdata_r[2:0];
      if (wr_program_protect_reg) program_protect_reg_r <= wdata_r[7:0];
      if (wr_data_protect_reg) data_protect_reg_r <= wdata_r[7:0];
    end
  end

  // ************************************************
  // command array, one word per entry
  // ************************************************
  // results land in word 1; bus writes are locked out while a command runs
  for (genvar i = 0; i < CCOB_WORDS; i++) begin : g_ccob
    wire sel = wr_ccob && command_index_field_r == 3'(i);
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        ccob_r[i] <= 16'h0000;
      end else if (sel) begin
        if (wstrb_r[0]) ccob_r[i][7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) ccob_r[i][15:8] <= wdata_r[15:8];
      end else if (i == 1 && run_done && cmd_r == C_RDONCE) begin
        ccob_r[i] <= once_word_r;
      end
    end
  end

  // ************************************************
  // sequencer: launch, time base, completion
  // ************************************************
  // the run length is counted in time-base ticks so the divider matters
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      cmd_r <= 8'h00;
      pre_r <= '0;
      ticks_r <= 8'h00;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r <= ST_RUN;
            cmd_r <= lcmd;
            pre_r <= '0;
            ticks_r <= 8'h00;
          end
        end
        ST_RUN: begin
          pre_r <= tick ? '0 : pre_r + 1'b1;
          if (run_done) st_r <= ST_IDLE;
          else if (tick) ticks_r <= ticks_r + 8'h01;
        end
      endcase
    end
  end

  // ************************************************
  // status flags
  // ************************************************
  // clears come first so a hardware set in the same cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      command_complete_flag_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      mg0_r <= 1'b0;
    end else begin
      if (wr_stat && wdata_r[ST_ACCESS_ERROR_FLAG]) access_error_flag_r <= 1'b0;
      if (wr_stat && wdata_r[ST_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_r <= 1'b0;
      if (launch) begin
        if (acc_fail) access_error_flag_r <= 1'b1;
        else if (!prot_ok) protection_violation_flag_r <= 1'b1;
        else begin
          command_complete_flag_r <= 1'b0;
          mg0_r <= 1'b0;
        end
      end
      if (run_done) begin
        command_complete_flag_r <= 1'b1;
        if (cmd_r inside {C_EVALL, C_EVBLK, C_EVPSEC, C_EVDSEC}) mg0_r <= !erased_r;
        if (cmd_r == C_VFYKEY && key_in != BKDOOR_KEY) access_error_flag_r <= 1'b1;
      end
    end
  end

  // ************************************************
  // memory effects of finished commands
  // ************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      erased_r <= 1'b1;
      once_word_r <= 16'hFFFF;
      once_done_r <= 1'b0;
      sec_rel_r <= 1'b0;
    end else if (run_done) begin
      unique case (cmd_r)
        C_PGMP, C_PGMD: erased_r <= 1'b0;
        C_ERALL, C_ERBLK, C_ERPSEC, C_ERDSEC: erased_r <= 1'b1;
        C_UNSEC: begin
          erased_r <= 1'b1;
          sec_rel_r <= 1'b1;
        end
        C_VFYKEY: if (key_in == BKDOOR_KEY) sec_rel_r <= 1'b1;
        C_PGMONCE: begin
          once_word_r <= ccob_r[2];
          once_done_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign security_released = sec_rel_r;

  // ************************************************
  // assertions
  // ************************************************
  rsv_reads_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_go && rd_ix == IX_RSV7 |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("reserved register read not zero");
  div_flag_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_div |=> div_ld_r ##1 div_ld_r)
    else $error("divider loaded flag not set");
  no_div_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && is_pe && !div_ld_r |=> access_error_flag_r && command_complete_flag_r && st_r == ST_IDLE)
    else $error("program or erase ran without divider");
  busy_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !command_complete_flag_r |=> $stable(ccob_r[0]) && $stable(command_index_field_r))
    else $error("command array changed while busy");
  index_select_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_go && rd_ix == IX_CCOB && command_index_field_r == 3'h0 |=> s_axi_rdata[15:0] == $past(ccob_r[0]))
    else $error("index did not select word zero");
  launch_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    start |=> !command_complete_flag_r && st_r == ST_RUN)
    else $error("launch did not clear completion flag");
  done_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(command_complete_flag_r) |-> !command_complete_flag_r [*2] ##[0:1000] command_complete_flag_r)
    else $error("completion flag not returned");
  verify_ok_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && (lcmd == C_EVALL || lcmd == C_EVBLK) |=> !command_complete_flag_r && !access_error_flag_r)
    else $error("erase verify refused");
  special_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && (lcmd == C_ERALL || lcmd == C_UNSEC) && !sp |=> access_error_flag_r && command_complete_flag_r)
    else $error("special-only command ran in normal mode");
  key_normal_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && lcmd == C_VFYKEY && sp |=> access_error_flag_r && command_complete_flag_r)
    else $error("key verify ran in special mode");
  field_margin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && lcmd == C_FLDMRG && !(sp && !sec_eff) |=> access_error_flag_r)
    else $error("field margin accepted outside unsecured special");
  secured_sp_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && lcmd == C_PGMP && sp && sec_eff |=> access_error_flag_r && command_complete_flag_r)
    else $error("program ran in secured special mode");
  erall_prot_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && !acc_fail && lcmd == C_ERALL && !(pf_open && data_protect_reg_r[DF_OPEN]) |=> protection_violation_flag_r && command_complete_flag_r)
    else $error("erase all ran while protected");
  bad_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && !cmd_ok |=> access_error_flag_r && command_complete_flag_r && st_r == ST_IDLE)
    else $error("invalid command not refused");
endmodule
`default_nettype wire
